// ==== wdt_pkg.sv ====
/*
 * package of the watchdog block: register offsets, field positions,
 * reset values and timing constants.
 * assumes an 8-bit register port and one oscillator clock.
 */
package wdt_pkg;

    // register offsets
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h9F;
    localparam logic [7:0] SYSTEM_CONTROL_ADDR = 8'hBF;

    // watchdog_control fields
    localparam int WD_ENABLE_POS = 7;
    localparam int WD_CLEAR_POS = 5;
    localparam int WD_PRESCALE_LSB = 0;
    localparam int WD_PRESCALE_W = 3;

    // system_control fields
    localparam int WD_RESET_FLAG_POS = 7;
    localparam int ALE_INHIBIT_POS = 0;

    // reset values
    localparam logic WD_ENABLE_RST = 1'b0;
    localparam logic [2:0] WD_PRESCALE_RST = 3'h0;
    localparam logic WD_RESET_FLAG_RST = 1'b0;
    localparam logic ALE_INHIBIT_RST = 1'b0;

    // counter and divider
    localparam int WD_COUNT_W = 16;
    localparam int PRESCALE_W = 10;
    localparam int PRESCALE_MIN_SHIFT = 3;
    localparam int ALE_DIV = 6;
    localparam int ALE_CNT_W = 3;

    // length of the internal reset pulse on overflow, in ns
    localparam int WD_RESET_PULSE_NS = 32;
    localparam int CLK_PERIOD_NS = 4;
    localparam int WD_RESET_CYCLES_INT =
        (WD_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WD_RESET_CYCLES = WD_RESET_CYCLES_INT[3:0];

endpackage

// ==== wdt_prescaler.sv ====
/*
 * prescaler of the watchdog: an oscillator divider, held at zero while run is low, with a
 * one-cycle tick every 8 to 1024 clocks, picked by a 3-bit select.
 * assumes clear restarts the divider at zero.
 */
`timescale 1ns/1ps

module wdt_prescaler (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] select,
    // tick out
    output logic tick
);

    logic [wdt_pkg::PRESCALE_W-1:0] div_reg;
    logic [wdt_pkg::PRESCALE_W-1:0] div_next;
    logic [wdt_pkg::PRESCALE_W-1:0] div_mask;
    logic [wdt_pkg::PRESCALE_W-1:0] one_shift;

    ////////////////////////////////////////////////////////////////////

    // division is 8 << select, so the mask is that minus one
    assign one_shift = wdt_pkg::PRESCALE_W'(1) <<
        (wdt_pkg::PRESCALE_MIN_SHIFT + {28'h0, select});
    assign div_mask = one_shift - wdt_pkg::PRESCALE_W'(1);
    assign tick = run && !restart && ((div_reg & div_mask) == div_mask);
    assign div_next = (restart || !run) ? '0 :
        div_reg + wdt_pkg::PRESCALE_W'(1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

endmodule

// ==== wdt_top.sv ====
/*
 * watchdog with reset status: 16-bit counter, prescaler, control and
 * status registers, overflow reset and address latch clock.
 * assumes a synchronous 8-bit register port and an outside reset
 * controller that feeds hw reset into rst_n.
 */
//
// Behaviour
// - 16-bit up-counter; overflow asserts the device reset output.
// - counting clock comes from the oscillator clock only.
// - counter stays stopped until enable bit 7 is written one.
// - when enabled, count once per prescaled tick.
// - enable bit clears on hardware reset and on watchdog reset.
// - writing one to clear bit 5 zeroes the counter and restarts it.
// - select 000 divides by 8, doubling each step up to 1024.
// - timeout is 65536 prescaled ticks.
// - watchdog overflow sets the reset flag at system bit 7.
// - bit 0 of system control set stops the clock on the latch pin.
`timescale 1ns/1ps

module wdt_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // device outputs
    output logic wd_reset,
    output logic addr_latch_clock,
    output logic [15:0] watchdog_counter
);

    logic wd_enable_bit_reg;
    logic wd_enable_bit_next;
    logic [2:0] wd_prescale_select_reg;
    logic [2:0] wd_prescale_select_next;
    logic wd_reset_flag_reg;
    logic wd_reset_flag_next;
    logic addr_latch_clock_inhibit_reg;
    logic addr_latch_clock_inhibit_next;
    logic [wdt_pkg::WD_COUNT_W-1:0] count_reg;
    logic [wdt_pkg::WD_COUNT_W-1:0] count_next;
    logic [3:0] rst_cnt_reg;
    logic [3:0] rst_cnt_next;
    logic [wdt_pkg::ALE_CNT_W-1:0] ale_cnt_reg;
    logic [wdt_pkg::ALE_CNT_W-1:0] ale_cnt_next;
    logic ale_reg;
    logic ale_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    logic wr_ctl;
    logic wr_sys;
    logic clear_strobe;
    logic tick;
    logic overflow;
    logic wd_rst_active;
    logic ale_wrap;
    logic [7:0] ctl_view;
    logic [7:0] sys_view;

    ////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    assign wr_ctl = reg_wr && hit(reg_addr, wdt_pkg::WATCHDOG_CONTROL_ADDR);
    assign wr_sys = reg_wr && hit(reg_addr, wdt_pkg::SYSTEM_CONTROL_ADDR);
    assign clear_strobe = wr_ctl && reg_wdata[wdt_pkg::WD_CLEAR_POS];

    ////////////////////////////////////////////////////////////////////
    // prescaler

    wdt_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(wd_enable_bit_reg),
        .restart(clear_strobe || wd_rst_active),
        .select(wd_prescale_select_reg),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // counter and overflow reset

    // overflow: all ones and another tick arrives
    assign overflow = tick && (&count_reg);
    assign wd_rst_active = (rst_cnt_reg != 4'h0);
    assign wd_reset = wd_rst_active;

    assign count_next = (clear_strobe || wd_rst_active) ? '0 :
        (tick ? count_reg + wdt_pkg::WD_COUNT_W'(1) : count_reg);

    assign rst_cnt_next = overflow ? wdt_pkg::WD_RESET_CYCLES :
        (wd_rst_active ? rst_cnt_reg - 4'h1 : rst_cnt_reg);

    ////////////////////////////////////////////////////////////////////
    // control registers

    // the watchdog reset clears the enable, and a write cannot override
    assign wd_enable_bit_next = (overflow || wd_rst_active) ? 1'b0 :
        (wr_ctl ? reg_wdata[wdt_pkg::WD_ENABLE_POS] :
        wd_enable_bit_reg);
    assign wd_prescale_select_next = wd_rst_active ?
        wdt_pkg::WD_PRESCALE_RST :
        (wr_ctl ? reg_wdata[wdt_pkg::WD_PRESCALE_LSB +:
        wdt_pkg::WD_PRESCALE_W] : wd_prescale_select_reg);

    // set by overflow wins over a software clear
    assign wd_reset_flag_next = overflow ? 1'b1 :
        (wr_sys && !reg_wdata[wdt_pkg::WD_RESET_FLAG_POS]) ? 1'b0 :
        wd_reset_flag_reg;
    assign addr_latch_clock_inhibit_next = wd_rst_active ?
        wdt_pkg::ALE_INHIBIT_RST :
        (wr_sys ? reg_wdata[wdt_pkg::ALE_INHIBIT_POS] :
        addr_latch_clock_inhibit_reg);

    ////////////////////////////////////////////////////////////////////
    // address latch clock, oscillator divided by six

    assign ale_wrap =
        (ale_cnt_reg == wdt_pkg::ALE_CNT_W'(wdt_pkg::ALE_DIV / 2 - 1));
    assign ale_cnt_next = ale_wrap ? '0 :
        ale_cnt_reg + wdt_pkg::ALE_CNT_W'(1);
    assign ale_next = ale_wrap ? !ale_reg : ale_reg;
    assign addr_latch_clock = ale_reg && !addr_latch_clock_inhibit_reg;

    ////////////////////////////////////////////////////////////////////
    // read back

    assign ctl_view = {wd_enable_bit_reg, 1'b0, 1'b0, 2'b00,
        wd_prescale_select_reg};
    assign sys_view = {wd_reset_flag_reg, 6'h00,
        addr_latch_clock_inhibit_reg};
    assign rdata_next = !reg_rd ? 8'h00 :
        hit(reg_addr, wdt_pkg::WATCHDOG_CONTROL_ADDR) ? ctl_view :
        hit(reg_addr, wdt_pkg::SYSTEM_CONTROL_ADDR) ? sys_view : 8'h00;
    assign reg_rdata = rdata_reg;
    assign watchdog_counter = count_reg;

    ////////////////////////////////////////////////////////////////////
    // state

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wd_enable_bit_reg <= wdt_pkg::WD_ENABLE_RST;
            wd_prescale_select_reg <= wdt_pkg::WD_PRESCALE_RST;
            addr_latch_clock_inhibit_reg <= wdt_pkg::ALE_INHIBIT_RST;
            wd_reset_flag_reg <= wdt_pkg::WD_RESET_FLAG_RST;
            count_reg <= '0;
            rst_cnt_reg <= 4'h0;
        end else begin
            wd_enable_bit_reg <= wd_enable_bit_next;
            wd_prescale_select_reg <= wd_prescale_select_next;
            addr_latch_clock_inhibit_reg <= addr_latch_clock_inhibit_next;
            wd_reset_flag_reg <= wd_reset_flag_next;
            count_reg <= count_next;
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ale_cnt_reg <= '0;
            ale_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ale_cnt_reg <= ale_cnt_next;
            ale_reg <= ale_next;
            rdata_reg <= rdata_next;
        end
    end

endmodule

// ==== wdt_properties.sv ====
/* port checker of the watchdog block.
   assumes it is bound to wdt_top below. */
`timescale 1ns/1ps
module wdt_checker (
    // watched ports
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic wd_reset,
    input wire logic addr_latch_clock,
    input wire logic [15:0] watchdog_counter
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire ctl_wr = reg_wr && reg_addr == 8'h9F;
    wire sys_wr = reg_wr && reg_addr == 8'hBF;
    ////////////////////////////////////////////////////////////////////////
    a_rdata_slot: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data outside the read slot");
    a_count_step: assert property ($changed(watchdog_counter) |->
        watchdog_counter == $past(watchdog_counter) + 16'h1
        || watchdog_counter == 16'h0) else $error("counter jumped");
    a_clear_zero: assert property (ctl_wr && reg_wdata[5] |=>
        watchdog_counter == 16'h0) else $error("clear did not zero");
    a_pulse_len: assert property ($rose(wd_reset) |->
        wd_reset [*8] ##1 !wd_reset) else $error("reset pulse length");
    a_held_reset: assert property (wd_reset |->
        watchdog_counter == 16'h0) else $error("counter runs in reset");
    a_ale_high: assert property (addr_latch_clock [*3] |=>
        !addr_latch_clock) else $error("latch clock high too long");
    a_ale_inhibit: assert property (sys_wr && reg_wdata[0] |->
        ##3 !addr_latch_clock) else $error("latch clock not inhibited");
    a_idle_start: assert property ($rose(rst_n) |->
        (watchdog_counter == 16'h0 && !wd_reset) [*8])
        else $error("counter moved before enable");
endmodule
bind wdt_top wdt_checker u_wdt_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wd_reset(wd_reset),
    .addr_latch_clock(addr_latch_clock),
    .watchdog_counter(watchdog_counter));

// ==== wdt_top_test.sv ====
/* self-checking bench of the watchdog block.
   assumes wdt_top with its register port and the bound checker. */
`timescale 1ns/1ps
module wdt_top_test;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic wd_reset;
    logic addr_latch_clock;
    logic [15:0] watchdog_counter;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int highs;
    always #2 clk_sys = ~clk_sys;
    wdt_top u_wdt_top (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wd_reset(wd_reset),
        .addr_latch_clock(addr_latch_clock),
        .watchdog_counter(watchdog_counter));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task automatic wait_check_count(input int n, input logic [15:0] exp);
        repeat (n) @(posedge clk_sys);
        #1;
        check(watchdog_counter, exp);
    endtask
    task automatic count_highs(input int exp);
        highs = 0;
        repeat (12) begin
            @(posedge clk_sys);
            #1;
            highs += int'(addr_latch_clock);
        end
        check(16'(highs), 16'(exp));
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h9F, 8'h00);
        rd(8'hBF, 8'h00);
        wait_check_count(100, 16'h0000);
        $display("test reset values done");
        for (int s = 0; s < 8; s++) begin
            wr(8'h9F, 8'hA0 | 8'(s));
            wait_check_count((8 << s) * 4 + (4 << s), 16'h0004);
        end
        rd(8'h9F, 8'h87);
        $display("test prescale steps done");
        wr(8'h9F, 8'h87);
        wait_check_count(1, 16'h0004);
        wr(8'h9F, 8'hA7);
        wait_check_count(1, 16'h0000);
        $display("test counter clear done");
        wr(8'hBF, 8'h81);
        rd(8'hBF, 8'h01);
        count_highs(0);
        wr(8'hBF, 8'h00);
        repeat (3) @(posedge clk_sys);
        count_highs(6);
        $display("test latch clock done");
        wr(8'h9E, 8'hFF);
        rd(8'h9E, 8'h00);
        rd(8'h9F, 8'h87);
        $display("test unmapped done");
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h9F, 8'h00);
        rd(8'hBF, 8'h00);
        check({15'h0, wd_reset}, 16'h0000);
        $display("test hardware reset done");
        close_out();
    end
endmodule
